// *** hw/tic_pkg.sv ***
// package: register map, fields and reset values of the timer and interrupt control bank
package tic_pkg;
  localparam logic [7:0] TIC_ADDR_MODE    = 8'hf1;
  localparam logic [7:0] TIC_ADDR_COUNT   = 8'hf2;
  localparam logic [7:0] TIC_ADDR_PEND    = 8'hfa;
  localparam logic [7:0] TIC_ADDR_MASK    = 8'hfb;
  localparam logic [7:0] TIC_ADDR_POINTER = 8'hfd;
  localparam logic [7:0] TIC_ADDR_SPARE   = 8'hfe;
  localparam int TIC_MODE_SEL_LO  = 4;
  localparam int TIC_MODE_ENABLE  = 3;
  localparam int TIC_MODE_LOAD    = 2;
  localparam int TIC_PEND_COUNTER = 5;
  localparam int TIC_PEND_SOFT    = 4;
  localparam int TIC_PEND_SRC3    = 3;
  localparam int TIC_PEND_SRC2    = 2;
  localparam int TIC_PEND_SRC1    = 1;
  localparam int TIC_PEND_SRC0    = 0;
  localparam logic [7:0] TIC_MODE_WMASK    = 8'h3c;
  localparam logic [7:0] TIC_PEND_WMASK    = 8'h3f;
  localparam logic [7:0] TIC_POINTER_WMASK = 8'hf0;
  localparam logic [7:0] TIC_RST_MODE    = 8'h00;
  localparam logic [7:0] TIC_RST_PEND    = 8'h00;
  localparam logic [7:0] TIC_RST_MASK    = 8'h00;
  localparam logic [7:0] TIC_RST_POINTER = 8'h00;
  localparam logic [7:0] TIC_RST_SPARE   = 8'h00;
  localparam logic [7:0] TIC_RST_COUNT   = 8'h00;
  typedef enum logic [1:0] {
    TIC_IN_CLOCK   = 2'b00,
    TIC_IN_GATE    = 2'b01,
    TIC_IN_TRIG    = 2'b10,
    TIC_IN_RETRIG  = 2'b11
  } tic_inmode_e;
endpackage

// *** hw/tic_regs.sv ***
// module: timer mode, counter, pending flags, pointer and spare register bank
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module tic_regs (
  // clock and reset
  input  wire logic       CLK_SYS_IN,
  input  wire logic       RSTN_IN,
  // register port
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  // input lines, asynchronous
  input  wire logic       INPUT_LINE_FIRST_IN,
  input  wire logic       INPUT_LINE_SECOND_IN,
  input  wire logic       INPUT_LINE_THIRD_IN,
  input  wire logic       EXTERNAL_COUNT_INPUT_IN,
  // outputs to core
  output logic      [3:0] WORKING_GROUP_POINTER_OUT,
  output logic            IRQ_OUT
);
  import tic_pkg::*;

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  logic [7:0] mode_reg;
  logic [7:0] count_reg;
  logic [7:0] init_reg;
  logic [5:0] pend_reg;
  logic [5:0] pend_next;
  logic [5:0] mask_reg;
  logic [3:0] pointer_reg;
  logic [7:0] spare_reg;
  logic       running_reg;
  logic [7:0] rdata_next;

  // synchronise pins; index 0 first, 1 second, 2 third, 3 timer input
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end else begin
      sync1_reg <= {EXTERNAL_COUNT_INPUT_IN, INPUT_LINE_THIRD_IN,
                    INPUT_LINE_SECOND_IN, INPUT_LINE_FIRST_IN};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire [3:0] rise = sync2_reg & ~prev_reg;
  wire [3:0] fall = ~sync2_reg & prev_reg;

  wire wr_mode    = WR_IN && (ADDR_IN == TIC_ADDR_MODE);
  wire wr_count   = WR_IN && (ADDR_IN == TIC_ADDR_COUNT);
  wire wr_pend    = WR_IN && (ADDR_IN == TIC_ADDR_PEND);
  wire wr_mask    = WR_IN && (ADDR_IN == TIC_ADDR_MASK);
  wire wr_pointer = WR_IN && (ADDR_IN == TIC_ADDR_POINTER);
  wire wr_spare   = WR_IN && (ADDR_IN == TIC_ADDR_SPARE);
  wire rd_pend    = RD_IN && (ADDR_IN == TIC_ADDR_PEND);
  // interrupt level sees a mask written in the same cycle as the flag
  wire [5:0] mask_next = wr_mask ? WDATA_IN[5:0] : mask_reg;

  wire [1:0] in_mode  = mode_reg[TIC_MODE_SEL_LO +: 2];
  wire       enabled  = mode_reg[TIC_MODE_ENABLE];
  wire       load_cmd = wr_mode && WDATA_IN[TIC_MODE_LOAD];
  wire       trig_edge = rise[3];
  wire       trig_mode = (in_mode == TIC_IN_TRIG) || (in_mode == TIC_IN_RETRIG);
  wire       retrig   = (in_mode == TIC_IN_RETRIG) && trig_edge;
  wire       tick     = (in_mode == TIC_IN_CLOCK) ? fall[3] :
                        (in_mode == TIC_IN_GATE)  ? sync2_reg[3] :
                        running_reg;
  wire       count_ev = enabled && tick && !load_cmd && !retrig;
  // 00h is 256: reaching 01h is the last count
  wire       at_end   = count_ev && (count_reg == 8'h01);

  // trigger modes: a one-shot that stops at end; retrigger restarts
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      running_reg <= 1'b0;
    end else if (!enabled || !trig_mode) begin
      running_reg <= 1'b0;
    end else if (trig_edge) begin
      running_reg <= 1'b1;
    end else if (at_end) begin
      running_reg <= 1'b0;
    end
  end

  // counter has no documented reset value; zero chosen for clean simulation
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      count_reg <= TIC_RST_COUNT;
      init_reg  <= TIC_RST_COUNT;
    end else begin
      if (wr_count) begin
        init_reg <= WDATA_IN;
      end
      if (load_cmd || retrig || at_end) begin
        count_reg <= init_reg;
      end else if (count_ev) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  // set wins over software clear and over read-clear
  always_comb begin
    pend_next = pend_reg;
    if (rd_pend) begin
      pend_next = 6'h00;
    end
    if (wr_pend) begin
      pend_next = WDATA_IN[5:0] & TIC_PEND_WMASK[5:0];
    end
    pend_next[TIC_PEND_COUNTER] = pend_next[TIC_PEND_COUNTER] | at_end;
    pend_next[TIC_PEND_SRC3] = pend_next[TIC_PEND_SRC3] | rise[1];
    pend_next[TIC_PEND_SRC2] = pend_next[TIC_PEND_SRC2] | fall[0];
    pend_next[TIC_PEND_SRC1] = pend_next[TIC_PEND_SRC1] | fall[2];
    pend_next[TIC_PEND_SRC0] = pend_next[TIC_PEND_SRC0] | fall[1];
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      mode_reg    <= TIC_RST_MODE;
      pend_reg    <= TIC_RST_PEND[5:0];
      mask_reg    <= TIC_RST_MASK[5:0];
      pointer_reg <= TIC_RST_POINTER[7:4];
      spare_reg   <= TIC_RST_SPARE;
    end else begin
      pend_reg <= pend_next;
      // load bit is a command, not stored; reserved bits held zero
      if (wr_mode) begin
        mode_reg <= WDATA_IN & TIC_MODE_WMASK & ~(8'h01 << TIC_MODE_LOAD);
      end
      if (wr_mask) begin
        mask_reg <= WDATA_IN[5:0];
      end
      if (wr_pointer) begin
        pointer_reg <= WDATA_IN[7:4];
      end
      if (wr_spare) begin
        spare_reg <= WDATA_IN;
      end
    end
  end

  always_comb begin
    unique case (ADDR_IN)
      TIC_ADDR_MODE:    rdata_next = mode_reg;
      TIC_ADDR_COUNT:   rdata_next = count_reg;
      TIC_ADDR_PEND:    rdata_next = {2'b00, pend_reg};
      TIC_ADDR_MASK:    rdata_next = {2'b00, mask_reg};
      TIC_ADDR_POINTER: rdata_next = {pointer_reg, 4'h0};
      TIC_ADDR_SPARE:   rdata_next = spare_reg;
      default:          rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      RDATA_OUT                 <= 8'h00;
      IRQ_OUT                   <= 1'b0;
      WORKING_GROUP_POINTER_OUT <= 4'h0;
    end else begin
      RDATA_OUT                 <= RD_IN ? rdata_next : 8'h00;
      IRQ_OUT                   <= |(pend_next & mask_next);
      WORKING_GROUP_POINTER_OUT <= wr_pointer ? WDATA_IN[7:4] : pointer_reg;
    end
  end

  a_mode_reset: assert property (@(posedge CLK_SYS_IN)
    $rose(RSTN_IN) |-> mode_reg == 8'h00)
    else $error("mode register not zero after reset");
  a_mode_reserved: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    (mode_reg & 8'hc7) == 8'h00)
    else $error("reserved or load mode bits stored");
  a_halt_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !enabled && !load_cmd && !retrig |=> $stable(count_reg))
    else $error("counter moved while halted");
  a_load_value: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    load_cmd && !wr_count |=> count_reg == $past(init_reg))
    else $error("load did not copy initial value");
  a_count_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    RD_IN && ADDR_IN == TIC_ADDR_COUNT |=> RDATA_OUT == $past(count_reg))
    else $error("counter read wrong");
  a_end_flag: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    at_end |=> pend_reg[TIC_PEND_COUNTER] && count_reg == $past(init_reg))
    else $error("end count did not flag and reload");
  a_src3_rise: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    rise[1] |=> pend_reg[TIC_PEND_SRC3])
    else $error("rising edge flag missed");
  a_gate_stop: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    in_mode == TIC_IN_GATE && !sync2_reg[3] && !load_cmd |=> $stable(count_reg))
    else $error("counted with gate low");
  a_spare_reset: assert property (@(posedge CLK_SYS_IN)
    $rose(RSTN_IN) |-> spare_reg == 8'h00 && pointer_reg == 4'h0)
    else $error("spare or pointer not cleared");
  a_soft_only: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !wr_pend && !pend_reg[TIC_PEND_SOFT] |=> !pend_reg[TIC_PEND_SOFT])
    else $error("soft flag set without write");
  a_irq_level: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    ##1 IRQ_OUT == |(pend_reg & mask_reg))
    else $error("interrupt output mismatch");

  // mode register: write, hold and read back
  a_mode_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_mode |=> mode_reg == ($past(WDATA_IN) & 8'h38))
    else $error("mode write not stored");

  a_mode_keep: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !wr_mode |=> $stable(mode_reg))
    else $error("mode register changed without write");

  a_mode_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    RD_IN && ADDR_IN == TIC_ADDR_MODE |=> RDATA_OUT == $past(mode_reg))
    else $error("mode read wrong");

  // input modes: which event moves the counter
  a_clock_tick: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    enabled && in_mode == TIC_IN_CLOCK && !fall[3] && !load_cmd |=> $stable(count_reg))
    else $error("clock mode counted without falling edge");

  a_clock_step: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    enabled && in_mode == TIC_IN_CLOCK && fall[3] && !load_cmd && count_reg != 8'h01
    |=> count_reg == $past(count_reg) - 8'h01)
    else $error("clock mode missed a falling edge");

  a_gate_step: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    enabled && in_mode == TIC_IN_GATE && sync2_reg[3] && !load_cmd && count_reg != 8'h01
    |=> count_reg == $past(count_reg) - 8'h01)
    else $error("gate mode did not count");

  a_trig_start: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    enabled && in_mode == TIC_IN_TRIG && trig_edge |=> running_reg)
    else $error("trigger edge did not start count");

  a_trig_idle: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    in_mode == TIC_IN_TRIG && !running_reg && !load_cmd |=> $stable(count_reg))
    else $error("trigger mode counted while idle");

  a_retrig_load: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    retrig |=> count_reg == $past(init_reg))
    else $error("retrigger did not restart count");

  a_oneshot_stop: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    at_end && in_mode == TIC_IN_TRIG && !trig_edge |=> !running_reg)
    else $error("one-shot kept running");

  a_run_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !enabled |=> !running_reg)
    else $error("run flag set while halted");

  // enable and load command
  a_count_enable: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    enabled && tick && !load_cmd && !retrig && count_reg != 8'h01
    |=> count_reg == $past(count_reg) - 8'h01)
    else $error("enabled counter missed an event");

  a_load_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_mode |=> !mode_reg[TIC_MODE_LOAD])
    else $error("load command stored");

  a_noload_keep: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_mode && !WDATA_IN[TIC_MODE_LOAD] && !count_ev && !retrig |=> $stable(count_reg))
    else $error("zero load bit changed counter");

  // counter register: write sets the initial value only
  a_count_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_count && !count_ev && !retrig |=> $stable(count_reg))
    else $error("counter write changed current count");

  a_init_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_count |=> init_reg == $past(WDATA_IN))
    else $error("initial value not stored");

  a_init_keep: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !wr_count |=> $stable(init_reg))
    else $error("initial value changed without write");

  a_full_count: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    count_ev && count_reg == 8'h00 |=> count_reg == 8'hff)
    else $error("zero did not count as 256");

  // pending flags: read clears, write replaces
  a_pend_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    RD_IN && ADDR_IN == TIC_ADDR_PEND |=> RDATA_OUT == {2'b00, $past(pend_reg)})
    else $error("pending read wrong");

  a_pend_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    rd_pend && !wr_pend && !at_end && !rise[1] && fall[2:0] == 3'b000
    |=> pend_reg == 6'h00)
    else $error("pending read did not clear");

  a_pend_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_pend && !at_end && !rise[1] && fall[2:0] == 3'b000
    |=> {2'b00, pend_reg} == ($past(WDATA_IN) & 8'h3f))
    else $error("pending write not stored");

  a_counter_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !at_end && !wr_pend && !pend_reg[TIC_PEND_COUNTER] |=> !pend_reg[TIC_PEND_COUNTER])
    else $error("counter flag set without end");

  a_soft_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_pend && WDATA_IN[TIC_PEND_SOFT] |=> pend_reg[TIC_PEND_SOFT])
    else $error("soft flag write lost");

  a_src3_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !rise[1] && !wr_pend && !pend_reg[TIC_PEND_SRC3] |=> !pend_reg[TIC_PEND_SRC3])
    else $error("rising flag set without edge");

  // input line flags
  a_src2_fall: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    fall[0] |=> pend_reg[TIC_PEND_SRC2])
    else $error("first line flag missed");

  a_src2_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !fall[0] && !wr_pend && !pend_reg[TIC_PEND_SRC2] |=> !pend_reg[TIC_PEND_SRC2])
    else $error("first line flag set without edge");

  a_src1_fall: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    fall[2] |=> pend_reg[TIC_PEND_SRC1])
    else $error("third line flag missed");

  a_src1_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !fall[2] && !wr_pend && !pend_reg[TIC_PEND_SRC1] |=> !pend_reg[TIC_PEND_SRC1])
    else $error("third line flag set without edge");

  a_src0_fall: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    fall[1] |=> pend_reg[TIC_PEND_SRC0])
    else $error("second line flag missed");

  a_src0_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !fall[1] && !wr_pend && !pend_reg[TIC_PEND_SRC0] |=> !pend_reg[TIC_PEND_SRC0])
    else $error("second line flag set without edge");

  // pointer and spare register
  a_ptr_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_pointer |=> {pointer_reg, 4'h0} == ($past(WDATA_IN) & 8'hf0))
    else $error("pointer write not stored");

  a_ptr_keep: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !wr_pointer |=> $stable(pointer_reg))
    else $error("pointer changed without write");

  a_ptr_out: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    WORKING_GROUP_POINTER_OUT == pointer_reg)
    else $error("pointer output differs from register");

  a_ptr_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    RD_IN && ADDR_IN == TIC_ADDR_POINTER |=> RDATA_OUT == {$past(pointer_reg), 4'h0})
    else $error("pointer read wrong");

  a_spare_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_spare |=> spare_reg == $past(WDATA_IN))
    else $error("spare write not stored");

  a_spare_keep: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !wr_spare |=> $stable(spare_reg))
    else $error("spare changed without write");

  a_spare_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    RD_IN && ADDR_IN == TIC_ADDR_SPARE |=> RDATA_OUT == $past(spare_reg))
    else $error("spare read wrong");

  // bus side: read data only after a strobe, mask store
  a_idle_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data without strobe");

  a_mask_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    wr_mask |=> {2'b00, mask_reg} == ($past(WDATA_IN) & 8'h3f))
    else $error("mask write not stored");

  a_mask_keep: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
    !wr_mask |=> $stable(mask_reg))
    else $error("mask changed without write");
endmodule // tic_regs

// *** dv/test_tic_regs.sv ***
// bench: register bank, pending flags, input lines and counter of tic_regs
`timescale 1ns/10ps
module test_tic_regs;
  import tic_pkg::*;
  logic       clk_sys, rstn, wr, rd, ext, rd_seen;
  logic [7:0] addr, wdata, rdata, n_val;
  logic [2:0] lines;
  logic [3:0] ptr;
  logic       irq;
  int         n_mismatch, compares, seed, i;
  logic [7:0] notes[$];
  logic [7:0] rise_code[3] = '{8'h00, 8'h08, 8'h00};
  logic [7:0] fall_code[3] = '{8'h04, 8'h01, 8'h02};

  tic_regs dut (
    .CLK_SYS_IN(clk_sys), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .INPUT_LINE_FIRST_IN(lines[0]),
    .INPUT_LINE_SECOND_IN(lines[1]), .INPUT_LINE_THIRD_IN(lines[2]),
    .EXTERNAL_COUNT_INPUT_IN(ext), .WORKING_GROUP_POINTER_OUT(ptr), .IRQ_OUT(irq));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic cmp_data(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a; wdata <= d; wr <= 1'b1; rd <= 1'b0;
  endtask

  // expected read data is noted here and checked by the watcher below
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a; rd <= 1'b1; wr <= 1'b0;
    notes.push_back(exp);
  endtask

  // every wait goes through here so no strobe is left high
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      wr <= 1'b0; rd <= 1'b0;
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      if (notes.size() == 0) cmp_data("unexpected read", 8'h00, 8'hff);
      else cmp_data("read data", notes.pop_front(), rdata);
    end
    rd_seen <= rd;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    seed = 30165;
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; ext = 1'b0; rd_seen = 1'b0;
    addr = 8'h00; wdata = 8'h00; lines = 3'b000;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_reg(TIC_ADDR_MODE, 8'h00);
    rd_reg(TIC_ADDR_PEND, 8'h00);
    rd_reg(TIC_ADDR_POINTER, 8'h00);
    rd_reg(TIC_ADDR_SPARE, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr_reg(TIC_ADDR_MODE, {2'b00, i[1:0], 4'b1000});
      rd_reg(TIC_ADDR_MODE, {2'b00, i[1:0], 4'b1000});
    end
    n_val = $random(seed);
    wr_reg(TIC_ADDR_SPARE, n_val);
    rd_reg(TIC_ADDR_SPARE, n_val);
    n_val = $random(seed);
    wr_reg(TIC_ADDR_POINTER, n_val & 8'hf0);
    rd_reg(TIC_ADDR_POINTER, n_val & 8'hf0);
    wr_reg(8'h10, 8'h55);
    rd_reg(8'h10, 8'h00);
    idle(1);
    cmp_pin("group pointer", {4'h0, n_val[7:4]}, {4'h0, ptr});
    // load a random initial value with counting halted
    n_val = $random(seed);
    wr_reg(TIC_ADDR_MODE, 8'h00);
    wr_reg(TIC_ADDR_COUNT, n_val);
    wr_reg(TIC_ADDR_MODE, 8'h04);
    rd_reg(TIC_ADDR_COUNT, n_val);
    rd_reg(TIC_ADDR_MODE, 8'h00);
    wr_reg(TIC_ADDR_MASK, 8'h3f);
    // external clock mode: two falling edges end a count of two
    wr_reg(TIC_ADDR_COUNT, 8'h02);
    wr_reg(TIC_ADDR_MODE, 8'h04);
    wr_reg(TIC_ADDR_MODE, 8'h08);
    for (i = 0; i < 2; i++) begin
      idle(1);
      ext <= 1'b1;
      idle(5);
      ext <= 1'b0;
      idle(6);
      rd_reg(TIC_ADDR_PEND, (i == 1) ? 8'h20 : 8'h00);
    end
    // gate mode with initial value 00 counts 256 clocks
    wr_reg(TIC_ADDR_MODE, 8'h00);
    wr_reg(TIC_ADDR_COUNT, 8'h00);
    wr_reg(TIC_ADDR_MODE, 8'h04);
    ext <= 1'b1;
    idle(5);
    wr_reg(TIC_ADDR_MODE, 8'h18);
    idle(240);
    rd_reg(TIC_ADDR_PEND, 8'h00);
    idle(30);
    cmp_pin("irq level", 8'h01, {7'h0, irq});
    rd_reg(TIC_ADDR_PEND, 8'h20);
    wr_reg(TIC_ADDR_MODE, 8'h00);
    ext <= 1'b0;
    idle(3);
    cmp_pin("irq level", 8'h00, {7'h0, irq});
    // trigger, then retrigger: one pass of three counts per rising edge
    wr_reg(TIC_ADDR_COUNT, 8'h03);
    wr_reg(TIC_ADDR_MODE, 8'h04);
    for (i = 0; i < 2; i++) begin
      wr_reg(TIC_ADDR_MODE, {3'b001, i[0], 4'b1000});
      idle(1);
      ext <= 1'b1;
      idle(12);
      rd_reg(TIC_ADDR_PEND, 8'h20);
      idle(10);
      rd_reg(TIC_ADDR_PEND, 8'h00);
      ext <= 1'b0;
      idle(4);
    end
    wr_reg(TIC_ADDR_MODE, 8'h00);
    // software flag held off by the mask, then read back and cleared
    wr_reg(TIC_ADDR_MASK, 8'h00);
    wr_reg(TIC_ADDR_PEND, 8'h10);
    idle(2);
    cmp_pin("irq level", 8'h00, {7'h0, irq});
    wr_reg(TIC_ADDR_MASK, 8'h3f);
    idle(2);
    cmp_pin("irq level", 8'h01, {7'h0, irq});
    rd_reg(TIC_ADDR_PEND, 8'h10);
    rd_reg(TIC_ADDR_PEND, 8'h00);
    // each input line raised then lowered
    for (i = 0; i < 3; i++) begin
      idle(1);
      lines[i] <= 1'b1;
      idle(6);
      rd_reg(TIC_ADDR_PEND, rise_code[i]);
      idle(1);
      lines[i] <= 1'b0;
      idle(6);
      rd_reg(TIC_ADDR_PEND, fall_code[i]);
    end
    idle(3);
    cmp_pin("notes left", 8'h00, notes.size());
    report_and_stop();
  end
endmodule // test_tic_regs
